// *** design/cc_timer_pkg.sv ***
// Package for the compare/capture/PWM timer: register map, field layout,
// reset values and shared types.
// Assumes a plain register port with 8-bit addresses and 16-bit data.
package cc_timer_pkg;

  // ************************************************************
  // Register offsets (word index on the plain port)
  // ************************************************************
  localparam logic [7:0] MODE_OFS    = 8'h00; // timer_mode_register
  localparam logic [7:0] CTRL_OFS    = 8'h01; // timer_control_register
  localparam logic [7:0] IRQEN_OFS   = 8'h02; // irq_enable_register
  localparam logic [7:0] STATUS_OFS  = 8'h03; // timer_status_register
  localparam logic [7:0] IOC0_OFS    = 8'h04; // io_control_0 (A,B)
  localparam logic [7:0] IOC1_OFS    = 8'h05; // io_control_1 (C,D)
  localparam logic [7:0] COUNTER_OFS = 8'h06; // main_counter
  localparam logic [7:0] GR_BASE_OFS = 8'h08; // general_reg_a..d at 08..0B
  localparam logic [7:0] PRESC_OFS   = 8'h0C; // prescaler divisor minus one

  // ************************************************************
  // Field positions
  // ************************************************************
  // Mode register
  localparam int MODE_START_BIT = 7;  // Count start
  localparam int MODE_BUFA_BIT  = 5;  // C buffers A
  localparam int MODE_BUFB_BIT  = 4;  // D buffers B
  localparam int MODE_PWMD_BIT  = 2;  // Pin D in PWM mode
  localparam int MODE_PWMC_BIT  = 1;
  localparam int MODE_PWMB_BIT  = 0;
  // Control register
  localparam int CTRL_CLR_BIT   = 7;  // clear_on_match_a
  localparam int CTRL_EXT_BIT   = 4;  // Count external clock pin
  localparam int CTRL_INIT_LSB  = 0;  // initial_level_a..d at bits 0..3
  // Enable / status register
  localparam int OVF_BIT        = 7;  // overflow flag and its enable
  localparam int FLAG_LSB       = 0;  // match flags a..d at bits 0..3
  // I/O control: per channel nibble, bit 2 = capture, bits 1:0 = action
  localparam int IOC_CAP_BIT    = 2;

  // ************************************************************
  // Reset values and encodings
  // ************************************************************
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] GR_RST    = 16'hFFFF;
  localparam logic [15:0] ZERO16    = 16'h0000;
  localparam logic [7:0]  PRESC_RST = 8'h00;   // 0 means divide by one
  localparam logic [7:0]  IOC_RST   = 8'h88;   // Reserved bits read 1
  localparam int          NCH       = 4;

  // Output action at compare match
  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_LOW    = 2'b01,
    ACT_HIGH   = 2'b10,
    ACT_TOGGLE = 2'b11
  } act_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Per-channel pin bundle
  typedef struct packed {
    logic [NCH-1:0] in;
    logic [NCH-1:0] out;
    logic [NCH-1:0] oe;
  } pins_t;

endpackage : cc_timer_pkg

// *** design/cc_gr_bank.sv ***
// Four 16-bit general registers with registered read data.
// Assumes one write port per word per cycle, driven by the timer core.
`timescale 1ns/1ps
`default_nettype none
module cc_gr_bank #(
  parameter int W = 16,
  parameter int N = 4
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [N-1:0]     we_i,    // Per-word write enable
  input  wire logic [N*W-1:0]   wdata_i, // Per-word write data
  input  wire logic [1:0]       raddr_i, // Read index
  output logic      [W-1:0]     rdata_o, // Registered read data
  output logic      [N*W-1:0]   words_o  // All words for comparators
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [N*W-1:0] mem_q; // Word storage

  // Writes and registered read; words reset to all ones, read data to zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mem_q   <= {N{cc_timer_pkg::GR_RST}};
      rdata_o <= cc_timer_pkg::ZERO16;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (we_i[i]) begin
          mem_q[i*W +: W] <= wdata_i[i*W +: W];
        end
      end
      rdata_o <= mem_q[raddr_i*W +: W];
    end
  end

  assign words_o = mem_q;

endmodule : cc_gr_bank
`default_nettype wire

// *** design/cc_timer.sv ***
// 16-bit compare/capture/PWM timer core with four general registers.
// Assumes a plain synchronous register port and pins synchronous to clk_i.
// Summary of operation
// - Stopped after reset; counts once started
// - Wrap to zero sets overflow flag, maybe irq
// - Match A with clear bit zeroes counter
// - Compare match drives pin low/high/toggle
// - Pin already at level stays unchanged
// - Capture counter on chosen pin edge
// - Capture A shifts old A into C
// - PWM: A period, B/C/D duty outputs
// - PWM level at A match, opposite at duty
// - PWM pins ignore output-action settings
// - Duty equal period: output does not change
// - PWM B with D buffer reloads B
// - Match event when counter leaves value
// - Clear on A gives period N+1
// - Compare match sets flag, maybe irq
// - Capture sets flag, maybe irq
// - Flag clears by read-one then write-zero
// - General registers reset to all ones
// - Action code 00 none,01 low,10 high,11 toggle
`timescale 1ns/1ps
`default_nettype none
module cc_timer #(
  parameter int CW = 16  // Counter width
) (
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  input  wire cc_timer_pkg::reg_req_t    req_i,       // Register request
  output logic [15:0]                    rdata_o,     // Read data, next cycle
  input  wire logic                      ext_clk_i,   // External count clock
  input  wire logic [3:0]                pin_in_i,    // Timer pins a..d in
  output logic [3:0]                     pin_out_o,   // Timer pins a..d out
  output logic [3:0]                     pin_oe_o,    // High while driving
  output logic                           timer_irq_request_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0]    mode;       // timer_mode_register
    logic [7:0]    ctrl;       // timer_control_register
    logic [7:0]    irq_en;     // irq_enable_register
    logic [7:0]    status;     // timer_status_register
    logic [7:0]    ioc0;       // io_control_0
    logic [7:0]    ioc1;       // io_control_1
    logic [CW-1:0] counter;    // main_counter
    logic [7:0]    presc;      // Prescale divisor minus one
    logic [7:0]    pdiv;       // Prescale count
    logic [3:0]    pin;        // Driven pin levels
    logic [3:0]    pin_prev;   // Last sampled pin inputs
    logic          ext_prev;   // Last sampled external clock
    logic [3:0]    match_pend; // Counter sits on a matching value
    logic [7:0]    rd_armed;   // Flags read while set
    logic          rd_reg;     // Read strobe seen last cycle
    logic          rd_gr;      // Read data from the general bank
    logic [15:0]   rd_val;     // Registered read data
  } state_t;

  state_t s_q;
  state_t s_d;

  // General register bank signals
  logic [3:0]    gr_we;     // Bank write enables
  logic [63:0]   gr_wdata;  // Bank write data
  logic [15:0]   gr_rdata;  // Bank read data
  logic [63:0]   gr_words;  // All general registers

  // ************************************************************
  // Helpers
  // ************************************************************
  // Channel's nibble of the I/O control pair
  function automatic logic [2:0] ioc_of(input logic [7:0] c0,
                                       input logic [7:0] c1,
                                       input int ch);
    logic [15:0] both;
    both   = {c1, c0};
    ioc_of = both[ch*4 +: 3];
  endfunction : ioc_of

  // Pin level after an output action
  function automatic logic apply_act(input logic [1:0] act,
                                     input logic cur);
    case (act)
      cc_timer_pkg::ACT_LOW:    apply_act = 1'b0;
      cc_timer_pkg::ACT_HIGH:   apply_act = 1'b1;
      cc_timer_pkg::ACT_TOGGLE: apply_act = ~cur;
      default:                  apply_act = cur;
    endcase
  endfunction : apply_act

  // Word of the general register bank
  function automatic logic [15:0] gr_of(input logic [63:0] w,
                                        input int ch);
    gr_of = w[ch*16 +: 16];
  endfunction : gr_of

  // Channels in PWM mode; channel a is the period and never is
  function automatic logic [3:0] pwm_of(input logic [7:0] m);
    pwm_of = {m[cc_timer_pkg::MODE_PWMD_BIT], m[cc_timer_pkg::MODE_PWMC_BIT],
              m[cc_timer_pkg::MODE_PWMB_BIT], 1'b0};
  endfunction : pwm_of

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic       tick;        // One count-clock enable
    logic       wrap;        // Counter leaves its maximum
    logic       clr_a;       // Periodic clear at match A
    logic [3:0] cmp_evt;     // Compare match events
    logic [3:0] cap_evt;     // Capture events
    logic [3:0] pwm;         // Channel in PWM mode
    logic [3:0] set_flags;   // Flags set this cycle
    logic [2:0] ioc;         // Channel control nibble
    logic       rise;        // Rising edge on a pin
    logic       fall;        // Falling edge on a pin
    logic       wr_any;      // Register write
    logic [7:0] clr_mask;    // Flags cleared by software
    tick      = 1'b0;
    wrap      = 1'b0;
    clr_a     = 1'b0;
    cmp_evt   = 4'h0;
    cap_evt   = 4'h0;
    pwm       = pwm_of(s_q.mode);
    set_flags = 4'h0;
    ioc       = 3'h0;
    rise      = 1'b0;
    fall      = 1'b0;
    wr_any    = req_i.wr;
    clr_mask  = 8'h00;
    s_d       = s_q;
    gr_we     = 4'h0;
    gr_wdata  = gr_words;

    // Count clock: prescaled internal or external rising edge
    s_d.ext_prev = ext_clk_i;
    if (s_q.mode[cc_timer_pkg::MODE_START_BIT]) begin
      if (s_q.ctrl[cc_timer_pkg::CTRL_EXT_BIT]) begin
        tick = ext_clk_i & ~s_q.ext_prev;
      end else if (s_q.pdiv == s_q.presc) begin
        tick = 1'b1;
      end
      if (s_q.pdiv == s_q.presc) begin
        s_d.pdiv = 8'h00;
      end else begin
        s_d.pdiv = s_q.pdiv + 8'h01;
      end
    end

    // Compare events fire when the counter leaves a matching value
    for (int ch = 0; ch < 4; ch++) begin
      ioc = ioc_of(s_q.ioc0, s_q.ioc1, ch);
      if (pwm[ch] || ch == 0 && |pwm || !ioc[cc_timer_pkg::IOC_CAP_BIT])
      begin
        if (tick && s_q.match_pend[ch]) begin
          cmp_evt[ch] = 1'b1;
        end
      end
    end

    // Counter update
    clr_a = cmp_evt[0] &&
            (s_q.ctrl[cc_timer_pkg::CTRL_CLR_BIT] || |pwm);
    if (tick) begin
      if (clr_a) begin
        s_d.counter = cc_timer_pkg::COUNT_RST;
      end else begin
        s_d.counter = s_q.counter + 16'h0001;
        wrap = (s_q.counter == cc_timer_pkg::COUNT_MAX);
      end
    end

    // Pin actions
    for (int ch = 0; ch < 4; ch++) begin
      ioc = ioc_of(s_q.ioc0, s_q.ioc1, ch);
      if (pwm[ch]) begin
        // Duty equal to period leaves the pin alone
        if (gr_of(gr_words, ch) != gr_of(gr_words, 0)) begin
          if (cmp_evt[0]) begin
            s_d.pin[ch] = s_q.ctrl[cc_timer_pkg::CTRL_INIT_LSB + ch];
          end else if (cmp_evt[ch]) begin
            s_d.pin[ch] = ~s_q.ctrl[cc_timer_pkg::CTRL_INIT_LSB + ch];
          end
        end
      end else if (cmp_evt[ch]) begin
        s_d.pin[ch] = apply_act(ioc[1:0], s_q.pin[ch]);
      end
    end

    // Capture edges on pins in capture mode
    s_d.pin_prev = pin_in_i;
    for (int ch = 0; ch < 4; ch++) begin
      ioc  = ioc_of(s_q.ioc0, s_q.ioc1, ch);
      rise = pin_in_i[ch] & ~s_q.pin_prev[ch];
      fall = ~pin_in_i[ch] & s_q.pin_prev[ch];
      if (ioc[cc_timer_pkg::IOC_CAP_BIT] && !pwm[ch] && !(ch == 0 && |pwm))
      begin
        case (ioc[1:0])
          2'b00:   cap_evt[ch] = rise;
          2'b01:   cap_evt[ch] = fall;
          default: cap_evt[ch] = rise | fall;
        endcase
      end
    end

    // Bank writes: software first, hardware events override
    if (wr_any && req_i.addr[7:2] == cc_timer_pkg::GR_BASE_OFS[7:2]) begin
      gr_we[req_i.addr[1:0]] = 1'b1;
      gr_wdata[req_i.addr[1:0]*16 +: 16] = req_i.wdata;
    end
    for (int ch = 0; ch < 4; ch++) begin
      if (cap_evt[ch]) begin
        gr_we[ch] = 1'b1;
        gr_wdata[ch*16 +: 16] = s_q.counter;
      end
    end
    // Capture A with C as buffer
    if (cap_evt[0] && s_q.mode[cc_timer_pkg::MODE_BUFA_BIT]) begin
      gr_we[2] = 1'b1;
      gr_wdata[2*16 +: 16] = gr_of(gr_words, 0);
    end
    // Compare A reloads from C when buffered
    if (cmp_evt[0] && s_q.mode[cc_timer_pkg::MODE_BUFA_BIT] && !cap_evt[0])
    begin
      gr_we[0] = 1'b1;
      gr_wdata[15:0] = gr_of(gr_words, 2);
    end
    // Compare B reloads from D when buffered
    if (cmp_evt[1] && s_q.mode[cc_timer_pkg::MODE_BUFB_BIT]) begin
      gr_we[1] = 1'b1;
      gr_wdata[31:16] = gr_of(gr_words, 3);
    end

    // Register writes
    if (wr_any) begin
      case (req_i.addr)
        cc_timer_pkg::MODE_OFS:  s_d.mode   = req_i.wdata[7:0];
        cc_timer_pkg::CTRL_OFS: begin
          s_d.ctrl = req_i.wdata[7:0];
          // Initial levels load the pins directly
          s_d.pin  = req_i.wdata[cc_timer_pkg::CTRL_INIT_LSB +: 4];
        end
        cc_timer_pkg::IRQEN_OFS: s_d.irq_en = req_i.wdata[7:0];
        cc_timer_pkg::IOC0_OFS:  s_d.ioc0   = req_i.wdata[7:0] |
                                              cc_timer_pkg::IOC_RST;
        cc_timer_pkg::IOC1_OFS:  s_d.ioc1   = req_i.wdata[7:0] |
                                              cc_timer_pkg::IOC_RST;
        cc_timer_pkg::COUNTER_OFS: s_d.counter = req_i.wdata;
        cc_timer_pkg::PRESC_OFS: s_d.presc  = req_i.wdata[7:0];
        cc_timer_pkg::STATUS_OFS: begin
          // Only armed flags written as zero clear
          clr_mask = s_q.rd_armed & ~req_i.wdata[7:0];
        end
        default: ;
      endcase
    end

    // Match pending for next count clock; taken after any counter write
    // so a stale count cannot fire a compare at the next count clock
    for (int ch = 0; ch < 4; ch++) begin
      s_d.match_pend[ch] = (s_d.counter == gr_of(gr_wdata, ch));
    end

    // Flags: set wins over a clear in the same cycle
    set_flags = cmp_evt | cap_evt;
    s_d.status = (s_q.status & ~clr_mask) |
                 {wrap, 3'b000, set_flags};
    if (wr_any && req_i.addr == cc_timer_pkg::STATUS_OFS) begin
      s_d.rd_armed = 8'h00;
    end else if (req_i.rd && req_i.addr == cc_timer_pkg::STATUS_OFS) begin
      s_d.rd_armed = s_q.status;
    end

    // Read path
    s_d.rd_gr  = req_i.rd &&
                 req_i.addr[7:2] == cc_timer_pkg::GR_BASE_OFS[7:2];
    s_d.rd_reg = req_i.rd;
    s_d.rd_val = cc_timer_pkg::ZERO16;
    if (req_i.rd) begin
      case (req_i.addr)
        cc_timer_pkg::MODE_OFS:    s_d.rd_val = {8'h00, s_q.mode};
        cc_timer_pkg::CTRL_OFS:    s_d.rd_val = {8'h00, s_q.ctrl};
        cc_timer_pkg::IRQEN_OFS:   s_d.rd_val = {8'h00, s_q.irq_en};
        cc_timer_pkg::STATUS_OFS:  s_d.rd_val = {8'h00, s_q.status};
        cc_timer_pkg::IOC0_OFS:    s_d.rd_val = {8'h00, s_q.ioc0};
        cc_timer_pkg::IOC1_OFS:    s_d.rd_val = {8'h00, s_q.ioc1};
        cc_timer_pkg::COUNTER_OFS: s_d.rd_val = s_q.counter;
        cc_timer_pkg::PRESC_OFS:   s_d.rd_val = {8'h00, s_q.presc};
        default:                   s_d.rd_val = cc_timer_pkg::ZERO16;
      endcase
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q            <= '0;
      s_q.ioc0       <= cc_timer_pkg::IOC_RST;
      s_q.ioc1       <= cc_timer_pkg::IOC_RST;
      s_q.counter    <= cc_timer_pkg::COUNT_RST;
      s_q.presc      <= cc_timer_pkg::PRESC_RST;
      s_q.match_pend <= 4'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // General registers live in their own bank
  cc_gr_bank #(
    .W (16),
    .N (4)
  ) u_bank (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .we_i    (gr_we),
    .wdata_i (gr_wdata),
    .raddr_i (req_i.addr[1:0]),
    .rdata_o (gr_rdata),
    .words_o (gr_words)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  // Read data only in the cycle after a read strobe, zero otherwise
  assign rdata_o   = !s_q.rd_reg ? cc_timer_pkg::ZERO16 :
                     s_q.rd_gr   ? gr_rdata : s_q.rd_val;
  // Pins drive whenever the channel is not capturing, or runs PWM
  always_comb begin
    logic [2:0] nib; // Channel control nibble
    logic [3:0] sel; // Channels in PWM mode
    nib = 3'h0;
    sel = pwm_of(s_q.mode);
    for (int ch = 0; ch < 4; ch++) begin
      nib          = ioc_of(s_q.ioc0, s_q.ioc1, ch);
      pin_oe_o[ch] = ~nib[cc_timer_pkg::IOC_CAP_BIT] | sel[ch];
    end
  end
  assign pin_out_o = s_q.pin;
  assign timer_irq_request_o = |(s_q.status & s_q.irq_en);

endmodule : cc_timer
`default_nettype wire

// *** verif/cc_timer_assertions.sv ***
// Port-level checker for the compare/capture/PWM timer core.
// Assumes it is bound to cc_timer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module cc_timer_assertions #(
  parameter int CW = 16  // Counter width, handed on by the bind
) (
  input wire logic                   clk_i,
  input wire logic                   reset_i,
  input wire cc_timer_pkg::reg_req_t req_i,
  input wire logic [15:0]            rdata_o,
  input wire logic                   ext_clk_i,
  input wire logic [3:0]             pin_in_i,
  input wire logic [3:0]             pin_out_o,
  input wire logic [3:0]             pin_oe_o,
  input wire logic                   timer_irq_request_o
);
  // ************************************************************
  // Shadow of software writes
  // ************************************************************
  typedef struct packed {
    logic       fresh; // No write since reset
    logic       run;   // Count start bit
    logic [2:0] pwm;   // PWM select for pins d,c,b
    logic [7:0] en;    // Interrupt enables
    logic [7:0] ioc0;  // I/O control for a,b
  } shadow_t;
  shadow_t sh_q;
  shadow_t sh_d;
  logic    wr_ctrl;    // Control write, reloads pin levels

  assign wr_ctrl = req_i.wr && (req_i.addr == cc_timer_pkg::CTRL_OFS);

  // Mirror only the fields the properties need; keeps the checker cheap
  always_comb begin
    sh_d = sh_q;
    if (req_i.wr) begin
      sh_d.fresh = 1'b0;
      case (req_i.addr)
        8'h00: begin
          sh_d.run = req_i.wdata[7];
          sh_d.pwm = req_i.wdata[2:0];
        end
        8'h02: sh_d.en = req_i.wdata[7:0];
        8'h04: sh_d.ioc0 = req_i.wdata[7:0];
        default: ;
      endcase
    end
    if (reset_i) begin
      sh_d = '0;
      sh_d.fresh = 1'b1;
      sh_d.ioc0 = cc_timer_pkg::IOC_RST;
    end
  end

  // Shadow register
  always_ff @(posedge clk_i) begin
    sh_q <= sh_d;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ************************************************************
  // Properties
  // ************************************************************
  property p_unmapped;
    req_i.rd && (req_i.addr > 8'h0C) |=> rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read gave nonzero data");
  property p_gr_reset;
    sh_q.fresh && req_i.rd && (req_i.addr[7:2] == 6'h02)
      |=> rdata_o == cc_timer_pkg::GR_RST;
  endproperty
  a_gr_reset: assert property (p_gr_reset)
    else $error("general register not all ones after reset");
  property p_cnt_idle;
    sh_q.fresh && req_i.rd && (req_i.addr == 8'h06) |=> rdata_o == 16'h0000;
  endproperty
  a_cnt_idle: assert property (p_cnt_idle)
    else $error("counter moved before start");
  property p_irq_gate;
    (sh_q.en == 8'h00) && ($past(sh_q.en) == 8'h00) |-> !timer_irq_request_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("request raised with all enables off");
  property p_oe_pwm;
    |sh_q.pwm |-> (pin_oe_o[3:1] & sh_q.pwm) == sh_q.pwm;
  endproperty
  a_oe_pwm: assert property (p_oe_pwm)
    else $error("PWM pin not driven");
  property p_oe_cap_a;
    pin_oe_o[0] != sh_q.ioc0[cc_timer_pkg::IOC_CAP_BIT];
  endproperty
  a_oe_cap_a: assert property (p_oe_cap_a)
    else $error("pin a drive does not follow capture select");
  property p_ctrl_pins;
    wr_ctrl |=> pin_out_o == $past(req_i.wdata[3:0]);
  endproperty
  a_ctrl_pins: assert property (p_ctrl_pins)
    else $error("pins not at initial levels after control write");
  property p_stopped;
    !sh_q.run && !wr_ctrl |=> $stable(pin_out_o);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("pin changed while counter stopped");

  c_irq: cover property ($rose(timer_irq_request_o));
  c_pwm: cover property (|sh_q.pwm ##1 $fell(pin_out_o[1]));
  c_cap: cover property (sh_q.ioc0[2] && $rose(pin_in_i[0]));
endmodule : cc_timer_assertions

bind cc_timer cc_timer_assertions #(.CW(CW)) cc_timer_assertions_i (
  .clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .rdata_o(rdata_o),
  .ext_clk_i(ext_clk_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
  .pin_oe_o(pin_oe_o), .timer_irq_request_o(timer_irq_request_o)
);
`default_nettype wire

// *** verif/compare_capture_pwm_timer_tb.sv ***
// Self-checking bench for the compare/capture/PWM timer core.
// Assumes the core runs from a 200 MHz clock with prescaler left at 0.
`timescale 1ns/1ps
`default_nettype none
module compare_capture_pwm_timer_tb;
  // ************************************************************
  // Signals and table
  // ************************************************************
  logic                   clk_i;
  logic                   reset_i;
  cc_timer_pkg::reg_req_t req_i;
  logic [15:0]            rdata_o;
  logic                   ext_clk_i;  // External count clock
  logic [3:0]             pin_in_i;
  logic [3:0]             pin_out_o;
  logic [3:0]             pin_oe_o;
  logic                   timer_irq_request_o;
  int                     num_errors;
  int                     checks_done;
  logic [15:0]            val;
  int                     n;
  typedef struct {
    logic [7:0] addr; logic wr; logic [15:0] wdata; logic [15:0] exp;
  } row_t;
  // Reset values, unmapped read, word readback of a stopped counter
  row_t rows [9] = '{
    '{8'h08, 1'b0, 16'h0000, 16'hFFFF}, '{8'h09, 1'b0, 16'h0000, 16'hFFFF},
    '{8'h0A, 1'b0, 16'h0000, 16'hFFFF}, '{8'h0B, 1'b0, 16'h0000, 16'hFFFF},
    '{8'h06, 1'b0, 16'h0000, 16'h0000}, '{8'h05, 1'b0, 16'h0000, 16'h0088},
    '{8'h0D, 1'b0, 16'h0000, 16'h0000}, '{8'h09, 1'b1, 16'h1234, 16'h1234},
    '{8'h06, 1'b1, 16'hFFF0, 16'hFFF0}};

  cc_timer cc_timer_i (
    .clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .rdata_o(rdata_o),
    .ext_clk_i(ext_clk_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .timer_irq_request_o(timer_irq_request_o));

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic close_out();
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One-cycle write strobe; dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req_i.wr <= 1'b1; req_i.addr <= a; req_i.wdata <= d;
    @(posedge clk_i);
    req_i.wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    req_i.rd <= 1'b1; req_i.addr <= a;
    @(posedge clk_i);
    req_i.rd <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask : rd
  // Cycles until pin b changes; bounded so a stuck pin ends the run
  task automatic meas(input int b, output int c);
    logic s;
    s = pin_out_o[b];
    c = 0;
    while (pin_out_o[b] === s && c < 100) begin
      @(negedge clk_i);
      c++;
    end
    if (c >= 100) begin
      num_errors++;
      close_out();
    end
  endtask : meas
  // High cycles of pin b over a window of four PWM periods
  task automatic cnt_hi(input int b, output int h);
    h = 0;
    repeat (40) begin
      @(negedge clk_i);
      if (pin_out_o[b] === 1'b1) h++;
    end
  endtask : cnt_hi

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    clk_i = 1'b0; reset_i = 1'b1; req_i = '0;
    ext_clk_i = 1'b0; pin_in_i = 4'h0;
    num_errors = 0; checks_done = 0;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, val);
      chk(val, rows[i].exp);
    end
    // Overflow from FFF0; all-ones registers a,c,d match on the wrap
    wr(8'h02, 16'h0080);
    wr(8'h00, 16'h0080);
    n = 0;
    while (timer_irq_request_o !== 1'b1 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    chk({15'h0000, timer_irq_request_o}, 16'h0001);
    wr(8'h00, 16'h0000);
    wr(8'h03, 16'h0000); // Zero write without a read is ignored
    @(negedge clk_i);
    chk({15'h0000, timer_irq_request_o}, 16'h0001);
    rd(8'h03, val);
    chk(val, 16'h008D);
    wr(8'h03, 16'h0000);
    @(negedge clk_i);
    chk({15'h0000, timer_irq_request_o}, 16'h0000);
    // Periodic count N=4: pin a toggles, pin b set high once
    wr(8'h06, 16'h0000); wr(8'h08, 16'h0004); wr(8'h09, 16'h0002);
    wr(8'h04, 16'h0023); wr(8'h01, 16'h0080); wr(8'h00, 16'h0080);
    meas(0, n);
    meas(0, n);
    chk(16'(n), 16'h0005);
    meas(0, n);
    chk(16'(n), 16'h0005);
    chk({15'h0000, pin_out_o[1]}, 16'h0001);
    rd(8'h03, val);
    chk(val & 16'h0003, 16'h0003);
    wr(8'h03, 16'h0000);
    // PWM on b and c, period 10, b duty 3, c equal to period
    wr(8'h00, 16'h0000); wr(8'h06, 16'h0000); wr(8'h08, 16'h0009);
    wr(8'h09, 16'h0003); wr(8'h0A, 16'h0009); wr(8'h0B, 16'h0003);
    wr(8'h04, 16'h0030); wr(8'h01, 16'h0006); wr(8'h00, 16'h0093);
    repeat (25) @(negedge clk_i);
    cnt_hi(1, n);
    chk(16'(n), 16'h0010);
    cnt_hi(2, n);
    chk(16'(n), 16'h0028);
    wr(8'h0B, 16'h0005); // New duty through the buffer
    repeat (25) @(negedge clk_i);
    rd(8'h09, val);
    chk(val, 16'h0005);
    cnt_hi(1, n);
    chk(16'(n), 16'h0018);
    // Capture: a both edges with c as buffer, d falling edge only
    wr(8'h00, 16'h0020); wr(8'h06, 16'h0100); wr(8'h08, 16'h0AAA);
    wr(8'h04, 16'h0006); wr(8'h05, 16'h0050);
    rd(8'h03, val); wr(8'h03, 16'h0000);
    pin_in_i <= 4'h1; // Held three clocks per edge
    repeat (3) @(posedge clk_i);
    rd(8'h08, val); chk(val, 16'h0100);
    rd(8'h0A, val); chk(val, 16'h0AAA);
    wr(8'h06, 16'h0200);
    pin_in_i <= 4'h9;
    repeat (3) @(posedge clk_i);
    rd(8'h0B, val); chk(val, 16'h0005);
    wr(8'h06, 16'h0300);
    pin_in_i <= 4'h0;
    repeat (3) @(posedge clk_i);
    rd(8'h08, val); chk(val, 16'h0300);
    rd(8'h0A, val); chk(val, 16'h0100);
    rd(8'h0B, val); chk(val, 16'h0300);
    rd(8'h03, val); chk(val & 16'h0009, 16'h0009);
    // External count clock: three pulses, each level held two clocks
    wr(8'h00, 16'h0000); wr(8'h06, 16'h0000);
    wr(8'h01, 16'h0010); wr(8'h00, 16'h0080);
    repeat (6) begin
      ext_clk_i <= ~ext_clk_i;
      repeat (2) @(posedge clk_i);
    end
    rd(8'h06, val); chk(val, 16'h0003);
    close_out();
  end
endmodule : compare_capture_pwm_timer_tb
`default_nettype wire
